/* File: core/modem_frontend_map.svh */
`ifndef MODEM_FRONTEND_MAP_SVH
`define MODEM_FRONTEND_MAP_SVH

// register offsets on the configuration port
`define OFS_RX_GAIN      4'h6
`define OFS_TX_SET       4'h7
`define OFS_RX_SET       4'h8
`define OFS_DIE_REV      4'hF

// reset value and writable-bit masks
`define REG_RESET        8'h00
`define GAIN_MASK        8'h3F
`define SET_MASK         8'hFD
`define RDATA_ZERO       8'h00

// field positions
`define GAIN_SRC_BIT     5
`define GAIN_CODE_HI     4
`define TX_DEMUX_BYP_BIT 0
`define TX_LSN_BIT       2
`define TX_QUIET_EN_BIT  3
`define TX_INTERP_HI     7
`define TX_INTERP_LO     4
`define RX_MUX_BYP_BIT   0
`define RX_LSN_BIT       2
`define RX_TRISTATE_BIT  3
`define CLKA_DIS_BIT     4
`define CLKB_DIS_BIT     5
`define CLKA_INV_BIT     6
`define CLKB_INV_BIT     7

// interpolation select codes
`define INTERP_BYPASS    4'h2
`define INTERP_LP4       4'h0
`define INTERP_LP2       4'h1
`define INTERP_BPADJ4    4'h4
`define INTERP_BPADJ2    4'h5
`define INTERP_BPLOW4    4'h8
`define INTERP_BPUP4     4'hC

// interpolation factors, clock half periods in cycles of clk_i
`define K_ONE            4'h1
`define K_TWO            4'h2
`define K_FOUR           4'h4
`define RX_CLK_HALF      4'h2
`define CNT_ONE          4'h1
`define CNT_ZERO         4'h0

// gain arithmetic, in dB except the gain code threshold and divisor
`define GAIN_MIN_DB      8'shFA
`define GAIN_STEP_DB     8'sh02
`define COARSE_STEP_DB   8'sh06
`define COARSE_OFS_DB    8'sh0C
`define COARSE_HI_DB     8'sh18
`define COARSE_WB_DB     8'sh12
`define FINE_WB_DB       8'sh0C
`define GAIN_CODE_HIGH   5'h12
`define GAIN_CODE_DIV    5'h03

`endif

/* File: core/modem_frontend_pkg.sv */
package modem_frontend_pkg;

   // interpolation filter mode, one-hot
   typedef enum logic [6:0] {
      IM_LP4    = 7'b000_0001,
      IM_LP2    = 7'b000_0010,
      IM_BYPASS = 7'b000_0100,
      IM_BPADJ4 = 7'b000_1000,
      IM_BPADJ2 = 7'b001_0000,
      IM_BPLOW4 = 7'b010_0000,
      IM_BPUP4  = 7'b100_0000
   } interp_mode_t;

   // receive port half-word phase, one-hot
   typedef enum logic [1:0] {
      RX_FIRST  = 2'b01,
      RX_SECOND = 2'b10
   } rx_phase_t;

endpackage

/* File: core/modem_frontend_port_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "modem_frontend_map.svh"

// Overview of operation
// - gain-source set: register value sets gain
// - gain-source resets zero: pins load gain
// - codes 0x00-0x11 give -6..28 dB
// - codes 0x12-0x1F clamp 30 dB wideband
// - high codes split 18/12 or 24/fine
// - tx bit0 bypasses demux, six-bit words
// - tx sync ignored while demux bypassed
// - tx bit2 expects low nibble first
// - tx bit3 quiet pin low powers down interpolators
// - tx bits 7:4 select interpolation filter
// - demux on: tx clock 2*fdac/K
// - demux off: tx clock fdac/K
// - rx bit0 bypass outputs six MSBs
// - rx bit2 sends low half first
// - rx bit3 floats receive data outputs
// - rx bits 4/5 stop clocks low
// - rx bit6 inverts transmit clock
// - rx bit7 inverts receive clock
// - die revision read-only, writes ignored
// - wideband filter enables the 30 dB clamp
// - gain readback shows gain in effect
module modem_frontend_port_config_regs
   import modem_frontend_pkg::*;
#(
   parameter logic [7:0] DIE_REVISION = 8'h5A  // value arbitrary
) (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic [3:0]         reg_addr_i,
   input  wire logic [7:0]         reg_wdata_i,
   input  wire logic               reg_wr_i,
   output logic      [7:0]         reg_rdata_o,
   input  wire logic               wideband_rx_filter_i,
   input  wire logic               gain_strobe_i,
   input  wire logic               tx_quiet_n_i,
   input  wire logic [5:0]         tx_data_i,
   input  wire logic               tx_sync_i,
   output logic      [11:0]        tx_word_o,
   output logic                    tx_word_valid_o,
   output logic                    interp_powerdown_o,
   output interp_mode_t            interp_mode_o,
   output logic                    tx_clk_o,
   input  wire logic [11:0]        adc_word_i,
   output logic      [5:0]         rx_data_o,
   output logic                    rx_data_oe_o,
   output logic                    rx_sync_o,
   output logic                    rx_clk_o,
   output logic signed [7:0]       rx_gain_db_o,
   output logic signed [7:0]       coarse_gain_stage_db_o,
   output logic signed [7:0]       fine_gain_stage_db_o
);

   // ---------------- register state ----------------
   logic [7:0]   gain_reg,    gain_next;     // {src, code}
   logic [7:0]   tx_set_reg,  tx_set_next;   // transmit path settings
   logic [7:0]   rx_set_reg,  rx_set_next;   // receive and clock output settings
   logic [7:0]   rdata_reg,   rdata_next;    // registered read data

   // register writes, pin gain loading and read mux
   always_comb begin
      gain_next   = gain_reg;
      tx_set_next = tx_set_reg;
      rx_set_next = rx_set_reg;
      // pin-based gain load only while source bit is low
      if (!gain_reg[`GAIN_SRC_BIT] && gain_strobe_i) begin
         gain_next = {gain_reg[7:5], tx_data_i[5:1]};
      end
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `OFS_RX_GAIN: gain_next   = reg_wdata_i & `GAIN_MASK;
            `OFS_TX_SET:  tx_set_next = reg_wdata_i & `SET_MASK;
            `OFS_RX_SET:  rx_set_next = reg_wdata_i & `SET_MASK;
            default: ;                                            // revision ignored
         endcase
      end
      // readback always shows the gain in effect
      unique case (reg_addr_i)
         `OFS_RX_GAIN: rdata_next = gain_reg;
         `OFS_TX_SET:  rdata_next = tx_set_reg;
         `OFS_RX_SET:  rdata_next = rx_set_reg;
         `OFS_DIE_REV: rdata_next = DIE_REVISION;
         default:      rdata_next = `RDATA_ZERO;
      endcase
   end

   // register flops, all cleared by reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gain_reg   <= `REG_RESET;
         tx_set_reg <= `REG_RESET;
         rx_set_reg <= `REG_RESET;
         rdata_reg  <= `REG_RESET;
      end else begin
         gain_reg   <= gain_next;
         tx_set_reg <= tx_set_next;
         rx_set_reg <= rx_set_next;
         rdata_reg  <= rdata_next;
      end
   end

   // ---------------- gain decode ----------------
   logic [4:0]        code;          // active gain code
   logic signed [7:0] total_db;      // nominal total gain
   logic signed [7:0] coarse_db;     // coarse stage share
   logic signed [7:0] coarse_raw;    // coarse before floor
   logic signed [7:0] total_next, coarse_next, fine_next;
   logic signed [7:0] total_reg, coarse_reg, fine_reg;

   // split total gain between coarse and fine stages
   always_comb begin
      code       = gain_reg[`GAIN_CODE_HI:0];
      total_db   = `GAIN_MIN_DB + `GAIN_STEP_DB * $signed({3'h0, code});
      coarse_raw = `COARSE_STEP_DB * $signed({3'h0, code / `GAIN_CODE_DIV})
                   - `COARSE_OFS_DB;
      coarse_db  = (coarse_raw < `GAIN_MIN_DB) ? `GAIN_MIN_DB : coarse_raw;
      if (code < `GAIN_CODE_HIGH) begin
         total_next  = total_db;
         coarse_next = coarse_db;
      end else if (wideband_rx_filter_i) begin
         total_next  = `COARSE_WB_DB + `FINE_WB_DB; // 30 dB clamp
         coarse_next = `COARSE_WB_DB;
      end else begin
         total_next  = total_db;                   // 30..56 dB
         coarse_next = `COARSE_HI_DB;
      end
      fine_next = total_next - coarse_next;
   end

   // gain decode flops
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         total_reg  <= `GAIN_MIN_DB;
         coarse_reg <= `GAIN_MIN_DB;
         fine_reg   <= `RDATA_ZERO;
      end else begin
         total_reg  <= total_next;
         coarse_reg <= coarse_next;
         fine_reg   <= fine_next;
      end
   end

   // ---------------- interpolation select ----------------
   interp_mode_t mode_next, mode_reg;   // decoded filter mode
   logic [3:0]   k_factor;              // interpolation factor
   logic         pd_next, pd_reg;       // interpolator power-down

   // decode filter select; unknown codes fall back to 4x low-pass
   always_comb begin
      unique case (tx_set_reg[`TX_INTERP_HI:`TX_INTERP_LO])
         `INTERP_BYPASS: mode_next = IM_BYPASS;
         `INTERP_LP2:    mode_next = IM_LP2;
         `INTERP_BPADJ4: mode_next = IM_BPADJ4;
         `INTERP_BPADJ2: mode_next = IM_BPADJ2;
         `INTERP_BPLOW4: mode_next = IM_BPLOW4;
         `INTERP_BPUP4:  mode_next = IM_BPUP4;
         default:        mode_next = IM_LP4;
      endcase
      unique case (mode_next)
         IM_BYPASS:         k_factor = `K_ONE;
         IM_LP2, IM_BPADJ2: k_factor = `K_TWO;
         default:           k_factor = `K_FOUR;
      endcase
      // quiet pin only acts when enabled
      pd_next = tx_set_reg[`TX_QUIET_EN_BIT] & ~tx_quiet_n_i;
   end

   // ---------------- clock generation ----------------
   logic [3:0] half_a;                         // tx clock half period
   logic [3:0] cnt_a_reg, cnt_a_next;          // tx clock divider
   logic [3:0] cnt_b_reg, cnt_b_next;          // rx clock divider
   logic       raw_a_reg, raw_a_next;          // tx clock before gating
   logic       raw_b_reg, raw_b_next;          // rx clock before gating
   logic       clka_reg,  clka_next;           // tx clock pin
   logic       clkb_reg,  clkb_next;           // rx clock pin
   logic       rise_a, fall_b;                 // internal clock events

   // dividers: demux doubles the tx clock rate
   always_comb begin
      half_a = tx_set_reg[`TX_DEMUX_BYP_BIT] ? (k_factor << 1)
                                             : k_factor;
      cnt_a_next = cnt_a_reg + `CNT_ONE;
      raw_a_next = raw_a_reg;
      if (cnt_a_next >= half_a) begin
         cnt_a_next = `CNT_ZERO;
         raw_a_next = ~raw_a_reg;
      end
      cnt_b_next = cnt_b_reg + `CNT_ONE;
      raw_b_next = raw_b_reg;
      if (cnt_b_next >= `RX_CLK_HALF) begin
         cnt_b_next = `CNT_ZERO;
         raw_b_next = ~raw_b_reg;
      end
      rise_a = raw_a_next & ~raw_a_reg;
      fall_b = ~raw_b_next & raw_b_reg;
      // disable holds low, else optional inversion
      clka_next = rx_set_reg[`CLKA_DIS_BIT] ? 1'b0
                : raw_a_next ^ rx_set_reg[`CLKA_INV_BIT];
      clkb_next = rx_set_reg[`CLKB_DIS_BIT] ? 1'b0
                : raw_b_next ^ rx_set_reg[`CLKB_INV_BIT];
   end

   // ---------------- transmit port ----------------
   logic [5:0]  first_reg,  first_next;    // held first nibble
   logic        have_reg,   have_next;     // first nibble captured
   logic [11:0] txw_reg,    txw_next;      // assembled word
   logic        txv_reg,    txv_next;      // word strobe

   // assemble words on each tx clock rising edge
   always_comb begin
      first_next = first_reg;
      have_next  = have_reg;
      txw_next   = txw_reg;
      txv_next   = 1'b0;
      if (rise_a) begin
         if (tx_set_reg[`TX_DEMUX_BYP_BIT]) begin
            txw_next  = {tx_data_i, 6'h00};  // sync not looked at
            txv_next  = 1'b1;
            have_next = 1'b0;
         end else if (tx_sync_i || !have_reg) begin
            first_next = tx_data_i;          // sync marks the first nibble
            have_next  = 1'b1;
         end else begin
            txw_next  = tx_set_reg[`TX_LSN_BIT] ? {tx_data_i, first_reg}
                                                : {first_reg, tx_data_i};
            txv_next  = 1'b1;
            have_next = 1'b0;
         end
      end
   end

   // ---------------- receive port ----------------
   rx_phase_t   ph_reg,   ph_next;     // half-word phase
   logic [11:0] adc_reg,  adc_next;    // word being sent
   logic [5:0]  rxd_reg,  rxd_next;    // rx data pins
   logic        rxs_reg,  rxs_next;    // rx sync pin
   logic        oe_reg,   oe_next;     // rx data enable

   // update rx data on the falling edge so the partner samples on rise
   always_comb begin
      ph_next  = ph_reg;
      adc_next = adc_reg;
      rxd_next = rxd_reg;
      rxs_next = rxs_reg;
      oe_next  = ~rx_set_reg[`RX_TRISTATE_BIT];
      if (fall_b) begin
         if (rx_set_reg[`RX_MUX_BYP_BIT]) begin
            rxd_next = adc_word_i[11:6];
            rxs_next = 1'b1;
            ph_next  = RX_FIRST;
         end else begin
            unique case (ph_reg)
               RX_FIRST: begin
                  adc_next = adc_word_i;
                  rxd_next = rx_set_reg[`RX_LSN_BIT] ? adc_word_i[5:0]
                                                     : adc_word_i[11:6];
                  rxs_next = 1'b1;
                  ph_next  = RX_SECOND;
               end
               RX_SECOND: begin
                  rxd_next = rx_set_reg[`RX_LSN_BIT] ? adc_reg[11:6]
                                                     : adc_reg[5:0];
                  rxs_next = 1'b0;
                  ph_next  = RX_FIRST;
               end
            endcase
         end
      end
   end

   // datapath and clock flops
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode_reg  <= IM_LP4;
         pd_reg    <= 1'b0;
         cnt_a_reg <= `CNT_ZERO;
         cnt_b_reg <= `CNT_ZERO;
         raw_a_reg <= 1'b0;
         raw_b_reg <= 1'b0;
         clka_reg  <= 1'b0;
         clkb_reg  <= 1'b0;
         first_reg <= 6'h00;
         have_reg  <= 1'b0;
         txw_reg   <= 12'h000;
         txv_reg   <= 1'b0;
         ph_reg    <= RX_FIRST;
         adc_reg   <= 12'h000;
         rxd_reg   <= 6'h00;
         rxs_reg   <= 1'b0;
         oe_reg    <= 1'b0;
      end else begin
         mode_reg  <= mode_next;
         pd_reg    <= pd_next;
         cnt_a_reg <= cnt_a_next;
         cnt_b_reg <= cnt_b_next;
         raw_a_reg <= raw_a_next;
         raw_b_reg <= raw_b_next;
         clka_reg  <= clka_next;
         clkb_reg  <= clkb_next;
         first_reg <= first_next;
         have_reg  <= have_next;
         txw_reg   <= txw_next;
         txv_reg   <= txv_next;
         ph_reg    <= ph_next;
         adc_reg   <= adc_next;
         rxd_reg   <= rxd_next;
         rxs_reg   <= rxs_next;
         oe_reg    <= oe_next;
      end
   end

   // outputs straight from flops
   assign reg_rdata_o            = rdata_reg;
   assign rx_gain_db_o           = total_reg;
   assign coarse_gain_stage_db_o = coarse_reg;
   assign fine_gain_stage_db_o   = fine_reg;
   assign interp_mode_o          = mode_reg;
   assign interp_powerdown_o     = pd_reg;
   assign tx_clk_o               = clka_reg;
   assign rx_clk_o               = clkb_reg;
   assign tx_word_o              = txw_reg;
   assign tx_word_valid_o        = txv_reg;
   assign rx_data_o              = rxd_reg;
   assign rx_sync_o              = rxs_reg;
   assign rx_data_oe_o           = oe_reg;

endmodule

`default_nettype wire

/* File: dv/modem_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module modem_ctrl_model (
   input  wire logic        clk_i,
   input  wire logic        tx_clk_i,
   input  wire logic        lsn_first_i,
   input  wire logic [11:0] word_i,
   input  wire logic        gain_load_i,
   input  wire logic [4:0]  gain_code_i,
   output logic      [5:0]  tx_data_o,
   output logic             tx_sync_o,
   output logic             gain_strobe_o
);
   logic clk_q  = 1'b0;  // transmit clock seen last edge
   logic second = 1'b0;  // second half of the word is up
   // step to the next nibble after each falling transmit clock
   always_ff @(posedge clk_i) begin
      clk_q <= tx_clk_i;
      if (clk_q && !tx_clk_i) begin
         second <= !second;
      end
   end
   // first nibble carries sync, order as configured
   assign tx_sync_o = !second;
   assign tx_data_o = gain_load_i ? {gain_code_i, 1'b0} :
                      ((second ^ lsn_first_i) ? word_i[5:0] : word_i[11:6]);
   assign gain_strobe_o = gain_load_i;
endmodule
`default_nettype wire

/* File: dv/modem_frontend_port_config_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "modem_frontend_map.svh"
module modem_frontend_port_config_regs_test;
   import modem_frontend_pkg::*;
   localparam logic [7:0] REV = 8'h3C;  // value arbitrary
   localparam logic [3:0] CODE [8] = '{4'h2, 4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'hC, 4'h3};
   localparam interp_mode_t MODE [8] = '{IM_BYPASS, IM_LP4, IM_LP2, IM_BPADJ4,
                                         IM_BPADJ2, IM_BPLOW4, IM_BPUP4, IM_LP4};
   localparam int PER [8] = '{2, 8, 4, 8, 4, 8, 8, 8};
   logic clk_i = 1'b0, rst_n_i = 1'b0, wr_en = 1'b0, wideband = 1'b0;
   logic quiet_n = 1'b1, lsn = 1'b0, gload = 1'b0, tx_sync, gstrobe;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata;
   logic [4:0] gcode = 5'h00;
   logic [11:0] word = 12'hA5C, adc = 12'h9C3, tx_word;
   logic [5:0] tx_data, rx_data;
   logic tx_valid, pd, tx_clk, oe, rx_sync, rx_clk, acc;
   interp_mode_t mode;
   logic signed [7:0] gain, coarse, fine;
   int fails = 0, n_checks = 0, tot, crs;
   modem_frontend_port_config_regs #(.DIE_REVISION(REV)) modem_frontend_port_config_regs_inst (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr_en), .reg_rdata_o(rdata), .wideband_rx_filter_i(wideband),
      .gain_strobe_i(gstrobe), .tx_quiet_n_i(quiet_n), .tx_data_i(tx_data),
      .tx_sync_i(tx_sync), .tx_word_o(tx_word), .tx_word_valid_o(tx_valid),
      .interp_powerdown_o(pd), .interp_mode_o(mode), .tx_clk_o(tx_clk), .adc_word_i(adc),
      .rx_data_o(rx_data), .rx_data_oe_o(oe), .rx_sync_o(rx_sync), .rx_clk_o(rx_clk),
      .rx_gain_db_o(gain), .coarse_gain_stage_db_o(coarse), .fine_gain_stage_db_o(fine));
   modem_ctrl_model modem_ctrl_model_inst (.clk_i(clk_i), .tx_clk_i(tx_clk),
      .lsn_first_i(lsn), .word_i(word), .gain_load_i(gload), .gain_code_i(gcode),
      .tx_data_o(tx_data), .tx_sync_o(tx_sync), .gain_strobe_o(gstrobe));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chkg(input string n, input int e, input logic signed [7:0] g);
      chk(n, 12'(8'(e)), 12'(g));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      cyc(1);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      cyc(1);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      cyc(1);
      addr = a;
      cyc(1);
      chk("rdata", {4'h0, e}, {4'h0, rdata});
   endtask
   task automatic txper(input int e);
      time t0;
      repeat (2) @(posedge tx_clk);
      t0 = $time;
      @(posedge tx_clk);
      chk("txper", 12'(e), 12'(($time - t0) / 10));
   endtask
   task automatic wv;
      repeat (3) begin
         do cyc(1); while (tx_valid !== 1'b1);
      end
   endtask
   task automatic ws(input logic v);
      do cyc(1); while (rx_sync !== v);
   endtask
   task automatic conclude;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // hang guard
   initial begin
      #100us;
      fails++;
      $display("[ERR] watchdog exp done got hang");
      conclude;
   end
   // main sequence
   initial begin
      cyc(10);
      rst_n_i = 1'b1;
      rd(`OFS_RX_GAIN, 8'h00);
      chkg("gain", -6, gain);
      wr(`OFS_TX_SET, 8'hFF);
      rd(`OFS_TX_SET, 8'hFD);
      wr(`OFS_RX_SET, 8'hFF);
      rd(`OFS_RX_SET, 8'hFD);
      wr(`OFS_DIE_REV, 8'h00);
      rd(`OFS_DIE_REV, REV);
      rd(4'h3, 8'h00);
      wr(`OFS_RX_SET, 8'h00);
      for (int w = 0; w < 2; w++) begin
         wideband = w[0];
         for (int c = 0; c < 22; c++) begin
            wr(`OFS_RX_GAIN, 8'(32 + c));
            cyc(2);
            tot = (c > 17 && w == 1) ? 30 : 2 * c - 6;
            crs = (c > 17) ? (w == 1 ? 18 : 24) : (c < 6 ? -6 : 6 * (c / 3) - 12);
            chkg("total", tot, gain);
            chkg("coarse", crs, coarse);
            chkg("fine", tot - crs, fine);
            rd(`OFS_RX_GAIN, 8'(32 + c));
         end
      end
      wr(`OFS_RX_GAIN, 8'h00);
      gcode = 5'h0B;
      gload = 1'b1;
      cyc(3);
      gload = 1'b0;
      chkg("pingain", 16, gain);
      rd(`OFS_RX_GAIN, 8'h0B);
      wr(`OFS_RX_GAIN, 8'h23);
      gcode = 5'h10;
      gload = 1'b1;
      cyc(3);
      gload = 1'b0;
      chkg("regsrc", 0, gain);
      wr(`OFS_TX_SET, 8'h00);
      wv;
      chk("txword", 12'hA5C, tx_word);
      chk("txclk", 12'h001, 12'(tx_clk));
      wr(`OFS_RX_SET, 8'h40);
      wv;
      chk("txclkinv", 12'h000, 12'(tx_clk));
      lsn = 1'b1;
      wr(`OFS_TX_SET, 8'h04);
      wv;
      chk("txlsn", 12'hA5C, tx_word);
      wr(`OFS_TX_SET, 8'h01);
      wv;
      chk("txbyp", 12'h001, 12'(tx_word === 12'hA40 || tx_word === 12'h700));
      word = 12'h000;
      wr(`OFS_TX_SET, 8'h08);
      quiet_n = 1'b0;
      cyc(3);
      chk("pd", 12'h001, 12'(pd));
      wr(`OFS_TX_SET, 8'h00);
      cyc(3);
      chk("pd", 12'h000, 12'(pd));
      quiet_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(`OFS_TX_SET, {CODE[i], 4'h0});
         txper(PER[i]);
         chk("mode", 12'(MODE[i]), 12'(mode));
      end
      wr(`OFS_TX_SET, 8'h01);
      txper(16);
      wr(`OFS_RX_SET, 8'h00);
      ws(1'b0);
      ws(1'b1);
      chk("rxclk", 12'h000, 12'(rx_clk));
      chk("rxhi", 12'h027, 12'(rx_data));
      chk("oe", 12'h001, 12'(oe));
      ws(1'b0);
      chk("rxlo", 12'h003, 12'(rx_data));
      wr(`OFS_RX_SET, 8'h04);
      ws(1'b0);
      ws(1'b1);
      chk("rxlsn", 12'h003, 12'(rx_data));
      wr(`OFS_RX_SET, 8'h80);
      ws(1'b0);
      ws(1'b1);
      chk("rxclkinv", 12'h001, 12'(rx_clk));
      wr(`OFS_RX_SET, 8'h01);
      cyc(8);
      chk("rxbyp", 12'h067, {5'h00, rx_sync, rx_data});
      wr(`OFS_RX_SET, 8'h08);
      cyc(3);
      chk("oe", 12'h000, 12'(oe));
      wr(`OFS_RX_SET, 8'h30);
      cyc(2);
      acc = 1'b0;
      repeat (12) begin
         cyc(1);
         acc = acc | tx_clk | rx_clk;
      end
      chk("clkstop", 12'h000, 12'(acc));
      conclude;
   end
endmodule
`default_nettype wire

/* File: dv/modem_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "modem_frontend_map.svh"
module modem_regs_props #(
   parameter logic [7:0] DIE_REVISION = 8'h5A  // value arbitrary
) (
   input wire logic              clk_i,
   input wire logic              rst_n_i,
   input wire logic [3:0]        reg_addr_i,
   input wire logic [7:0]        reg_wdata_i,
   input wire logic              reg_wr_i,
   input wire logic [7:0]        reg_rdata_o,
   input wire logic              tx_clk_o,
   input wire logic              rx_clk_o,
   input wire logic              rx_data_oe_o,
   input wire logic              rx_sync_o,
   input wire logic              tx_word_valid_o,
   input wire logic signed [7:0] rx_gain_db_o,
   input wire logic signed [7:0] coarse_gain_stage_db_o,
   input wire logic signed [7:0] fine_gain_stage_db_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic w8;  // write to the receive and clock register
   assign w8 = reg_wr_i && reg_addr_i == `OFS_RX_SET;
   a_tx_readback: assert property (
      reg_wr_i && reg_addr_i == `OFS_TX_SET ##1 reg_addr_i == `OFS_TX_SET
      |=> reg_rdata_o == ($past(reg_wdata_i, 2) & `SET_MASK)) else $error("tx readback");
   a_rev_fixed: assert property (
      reg_addr_i == `OFS_DIE_REV |=> reg_rdata_o == DIE_REVISION) else $error("revision");
   a_unmapped_zero: assert property (
      reg_addr_i inside {[4'h0:4'h5], [4'h9:4'hE]} |=> reg_rdata_o == 8'h00)
      else $error("unmapped read");
   a_rx_float: assert property (
      w8 && reg_wdata_i[3] ##1 !w8 |=> !rx_data_oe_o) else $error("rx oe");
   a_txclk_stop: assert property (
      w8 && reg_wdata_i[4] ##1 !w8 [*4] |=> !tx_clk_o && !$past(tx_clk_o)
      && !$past(tx_clk_o, 2) && !$past(tx_clk_o, 3)) else $error("tx clock runs");
   a_rxclk_stop: assert property (
      w8 && reg_wdata_i[5] ##1 !w8 [*4] |=> !rx_clk_o && !$past(rx_clk_o)
      && !$past(rx_clk_o, 2) && !$past(rx_clk_o, 3)) else $error("rx clock runs");
   a_byp_sync: assert property (
      w8 && reg_wdata_i[0] ##1 !w8 [*7] |-> rx_sync_o) else $error("bypass sync");
   a_gain_sum: assert property (
      rx_gain_db_o == coarse_gain_stage_db_o + fine_gain_stage_db_o
      && fine_gain_stage_db_o >= 8'sh00 && !rx_gain_db_o[0]) else $error("gain sum");
   a_coarse_set: assert property (
      coarse_gain_stage_db_o inside {8'shFA, 8'sh00, 8'sh06, 8'sh0C, 8'sh12, 8'sh18})
      else $error("coarse step");
   c_word: cover property (tx_word_valid_o);
   c_rx_word: cover property ($rose(rx_sync_o));
   c_float: cover property (!rx_data_oe_o);
endmodule
bind modem_frontend_port_config_regs modem_regs_props #(.DIE_REVISION(DIE_REVISION))
   props_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
   .tx_clk_o(tx_clk_o), .rx_clk_o(rx_clk_o), .rx_data_oe_o(rx_data_oe_o),
   .rx_sync_o(rx_sync_o), .tx_word_valid_o(tx_word_valid_o), .rx_gain_db_o(rx_gain_db_o),
   .coarse_gain_stage_db_o(coarse_gain_stage_db_o),
   .fine_gain_stage_db_o(fine_gain_stage_db_o));
`default_nettype wire
